// ===== src/otgvb_ctrl.sv
// module: otg supply control - resistor enables, supply enable and bus-valid source select
//
// Contract
// - drain resistor follows session control bit 3
// - pull-up resistor follows session control bit 4
// - supply enable is bit5 OR bit6, reset 0
// - select clear: report internal comparator
// - select and bypass: report indicator, optionally inverted
// - select, no bypass: indicator, optionally inverted, AND comparator
// - invert control is interface control bit 5
// - bypass control is interface control bit 6
// - select is session bit 7, default off
// - pin pull-down on while select clear
`timescale 1ns/10ps
module otgvb_ctrl (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [otgvb_pkg::OTGVB_ADDR_W-1:0] reg_addr,
  input wire logic [otgvb_pkg::OTGVB_DATA_W-1:0] reg_wdata,
  output logic [otgvb_pkg::OTGVB_DATA_W-1:0] reg_rdata,
  input wire logic ext_indicator_in,
  input wire logic bus_power_ok_cmp,
  input wire logic session_ok_cmp,
  output logic bus_power_drain_en,
  output logic bus_power_pulse_up_en,
  output logic ext_supply_enable_out,
  output logic ext_indicator_pulldown_en,
  output logic rxcmd_bus_power_ok,
  output logic rxcmd_session_ok
);
  import otgvb_pkg::*;

  logic [OTGVB_DATA_W-1:0] otg_session_control;
  logic [OTGVB_DATA_W-1:0] link_interface_control;
  logic ext_indicator_select;
  logic indicator_bypass_qualify;
  logic indicator_invert;
  logic supply_drive_req;
  logic supply_drive_ext_req;
  logic ext_clean;
  logic busok_clean;
  logic sessok_clean;
  logic indicator_level;
  logic next_bus_power_ok;

  otgvb_sync_if sync_bus ();

  assign sync_bus.raw = {session_ok_cmp, bus_power_ok_cmp, ext_indicator_in};

  otgvb_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .sif(sync_bus.dst)
  );

  assign ext_clean = sync_bus.clean[OTGVB_SYNC_EXT];
  assign busok_clean = sync_bus.clean[OTGVB_SYNC_BUSOK];
  assign sessok_clean = sync_bus.clean[OTGVB_SYNC_SESSOK];

  // control registers, written by the link controller
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      otg_session_control <= OTGVB_SESSION_CTRL_RST;
    end else if (reg_wr && reg_addr == OTGVB_SESSION_CTRL_ADDR) begin
      otg_session_control <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      link_interface_control <= OTGVB_LINK_IF_CTRL_RST;
    end else if (reg_wr && reg_addr == OTGVB_LINK_IF_CTRL_ADDR) begin
      link_interface_control <= reg_wdata;
    end
  end

  // read data lands one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OTGVB_SESSION_CTRL_ADDR: begin
          reg_rdata <= otg_session_control;
        end
        OTGVB_LINK_IF_CTRL_ADDR: begin
          reg_rdata <= link_interface_control;
        end
        default: begin
          reg_rdata <= '0;
        end
      endcase
    end
  end

  assign supply_drive_req = otg_session_control[OTGVB_DRIVE_BIT];
  assign supply_drive_ext_req = otg_session_control[OTGVB_DRIVE_EXT_BIT];
  assign ext_indicator_select = otg_session_control[OTGVB_EXT_SEL_BIT];
  assign indicator_invert = link_interface_control[OTGVB_INVERT_BIT];
  assign indicator_bypass_qualify = link_interface_control[OTGVB_BYPASS_BIT];

  // analog enables, registered so each pin changes two cycles after the write strobe
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_power_drain_en <= 1'b0;
      bus_power_pulse_up_en <= 1'b0;
      ext_supply_enable_out <= 1'b0;
      ext_indicator_pulldown_en <= 1'b1;
    end else begin
      bus_power_drain_en <= otg_session_control[OTGVB_DRAIN_BIT];
      bus_power_pulse_up_en <= otg_session_control[OTGVB_PULSE_UP_BIT];
      // either request enables the supply, for links with internal or external drive
      ext_supply_enable_out <= supply_drive_req | supply_drive_ext_req;
      // keep the unused pin from floating
      ext_indicator_pulldown_en <= ~ext_indicator_select;
    end
  end

  // the qualified mode is kept although the link is advised against it
  assign indicator_level = ext_clean ^ indicator_invert;

  always_comb begin
    if (!ext_indicator_select) begin
      next_bus_power_ok = busok_clean;
    end else if (indicator_bypass_qualify) begin
      next_bus_power_ok = indicator_level;
    end else begin
      next_bus_power_ok = indicator_level & busok_clean;
    end
  end

  // session-valid is reported apart so a peripheral link can start from it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rxcmd_bus_power_ok <= 1'b0;
      rxcmd_session_ok <= 1'b0;
    end else begin
      rxcmd_bus_power_ok <= next_bus_power_ok;
      rxcmd_session_ok <= sessok_clean;
    end
  end

  drain_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == OTGVB_SESSION_CTRL_ADDR ##1 1'b1 |=>
      bus_power_drain_en == $past(reg_wdata[OTGVB_DRAIN_BIT], 2))
    else $error("drain enable does not follow bit 3");

  pulse_up_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == OTGVB_SESSION_CTRL_ADDR |-> ##2
      bus_power_pulse_up_en == $past(reg_wdata[OTGVB_PULSE_UP_BIT], 2))
    else $error("pull-up enable does not follow bit 4");

  supply_or_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == OTGVB_SESSION_CTRL_ADDR ##1 !reg_wr |=>
      ext_supply_enable_out ==
        ($past(reg_wdata[OTGVB_DRIVE_BIT], 2) | $past(reg_wdata[OTGVB_DRIVE_EXT_BIT], 2)))
    else $error("supply enable is not the or of bits 5 and 6");

  supply_reset_a: assert property (@(posedge mclk)
    !reset_n |=> !ext_supply_enable_out && !supply_drive_req && !supply_drive_ext_req)
    else $error("supply drive bits not cleared by reset");

  internal_source_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !ext_indicator_select |=> rxcmd_bus_power_ok == $past(busok_clean))
    else $error("internal comparator not reported");

  bypass_source_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ext_indicator_select && indicator_bypass_qualify |=>
      rxcmd_bus_power_ok == ($past(ext_clean) ^ $past(indicator_invert)))
    else $error("pass-through indicator not reported");

  qualified_source_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ext_indicator_select && !indicator_bypass_qualify |=>
      rxcmd_bus_power_ok == (($past(ext_clean) ^ $past(indicator_invert)) & $past(busok_clean)))
    else $error("qualified indicator not reported");

  pulldown_sel_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == OTGVB_SESSION_CTRL_ADDR |-> ##2
      ext_indicator_pulldown_en == !$past(reg_wdata[OTGVB_EXT_SEL_BIT], 2))
    else $error("pin pull-down does not track select");

  select_default_a: assert property (@(posedge mclk)
    !reset_n |=> !ext_indicator_select ##1 ext_indicator_pulldown_en)
    else $error("select not off after reset");

  iface_bits_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_wr && reg_addr == OTGVB_LINK_IF_CTRL_ADDR |=>
      indicator_invert == $past(reg_wdata[5]) && indicator_bypass_qualify == $past(reg_wdata[6]))
    else $error("invert or bypass bit misplaced");

  // a stray write elsewhere must never disturb the supply or source controls
  session_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(reg_wr && reg_addr == OTGVB_SESSION_CTRL_ADDR) |=>
      $stable(otg_session_control))
    else $error("session control changed without a write");

  iface_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(reg_wr && reg_addr == OTGVB_LINK_IF_CTRL_ADDR) |=>
      $stable(link_interface_control))
    else $error("interface control changed without a write");

  session_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == OTGVB_SESSION_CTRL_ADDR |=>
      reg_rdata == $past(otg_session_control))
    else $error("session control read back wrong");

  iface_read_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_rd && reg_addr == OTGVB_LINK_IF_CTRL_ADDR |=>
      reg_rdata == $past(link_interface_control))
    else $error("interface control read back wrong");

  session_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> rxcmd_session_ok == $past(sessok_clean))
    else $error("session valid not passed through");

  enables_reset_a: assert property (@(posedge mclk)
    !reset_n |=> !bus_power_drain_en && !bus_power_pulse_up_en && ext_indicator_pulldown_en)
    else $error("resistor enables not at reset levels");
endmodule : otgvb_ctrl

// ===== src/otgvb_pkg.sv
// package: register map, field positions and reset values of the otg supply control block
package otgvb_pkg;
  localparam int OTGVB_ADDR_W = 6;
  localparam int OTGVB_DATA_W = 8;
  localparam int OTGVB_SYNC_W = 3;
  localparam logic [OTGVB_ADDR_W-1:0] OTGVB_SESSION_CTRL_ADDR = 6'h00;
  localparam logic [OTGVB_ADDR_W-1:0] OTGVB_LINK_IF_CTRL_ADDR = 6'h01;
  localparam logic [OTGVB_DATA_W-1:0] OTGVB_SESSION_CTRL_RST = 8'h00;
  localparam logic [OTGVB_DATA_W-1:0] OTGVB_LINK_IF_CTRL_RST = 8'h00;
  localparam int OTGVB_DRAIN_BIT = 3;
  localparam int OTGVB_PULSE_UP_BIT = 4;
  localparam int OTGVB_DRIVE_BIT = 5;
  localparam int OTGVB_DRIVE_EXT_BIT = 6;
  localparam int OTGVB_EXT_SEL_BIT = 7;
  localparam int OTGVB_INVERT_BIT = 5;
  localparam int OTGVB_BYPASS_BIT = 6;
  localparam int OTGVB_SYNC_EXT = 0;
  localparam int OTGVB_SYNC_BUSOK = 1;
  localparam int OTGVB_SYNC_SESSOK = 2;
  localparam logic [OTGVB_SYNC_W-1:0] OTGVB_SYNC_RST = 3'h0;
endpackage : otgvb_pkg

// ===== src/otgvb_sync_if.sv
// interface: raw pin levels into the synchroniser and their clean copies out
`timescale 1ns/10ps
interface otgvb_sync_if;
  logic [otgvb_pkg::OTGVB_SYNC_W-1:0] raw;
  logic [otgvb_pkg::OTGVB_SYNC_W-1:0] clean;
  modport src (output raw, input clean);
  modport dst (input raw, output clean);
endinterface : otgvb_sync_if

// ===== src/otgvb_sync.sv
// module: two flop synchroniser for the comparator and indicator pin levels
`timescale 1ns/10ps
module otgvb_sync (
  input wire logic mclk,
  input wire logic reset_n,
  otgvb_sync_if.dst sif
);
  import otgvb_pkg::*;

  logic [OTGVB_SYNC_W-1:0] stage1;
  logic [OTGVB_SYNC_W-1:0] stage2;

  // first stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      stage1 <= OTGVB_SYNC_RST;
      stage2 <= OTGVB_SYNC_RST;
    end else begin
      stage1 <= sif.raw;
      stage2 <= stage1;
    end
  end

  assign sif.clean = stage2;
endmodule : otgvb_sync

// ===== bench/otgvb_link_model.sv
// link controller model: register writes and reads over the block's strobe bus
`timescale 1ns/10ps
module otgvb_link_model (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [otgvb_pkg::OTGVB_ADDR_W-1:0] reg_addr,
  output logic [otgvb_pkg::OTGVB_DATA_W-1:0] reg_wdata
);
  import otgvb_pkg::*;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h3F;
    reg_wdata = 8'hA5;
  end
  // the link alone sets the select bit; the block never does it by itself
  task automatic wr(input logic [OTGVB_ADDR_W-1:0] a, input logic [OTGVB_DATA_W-1:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // released data shows the inverse so a stale sample cannot pass
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [OTGVB_ADDR_W-1:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask : rd
endmodule : otgvb_link_model

// ===== bench/otg_vbus_control_logic_tb.sv
// testbench: reset values, register bits, bus-valid source selection
`timescale 1ns/10ps
module otg_vbus_control_logic_tb;
  import otgvb_pkg::*;
  logic mclk;
  logic reset_n;
  logic reg_wr;
  logic reg_rd;
  logic [OTGVB_ADDR_W-1:0] reg_addr;
  logic [OTGVB_DATA_W-1:0] reg_wdata;
  logic [OTGVB_DATA_W-1:0] reg_rdata;
  logic ext_indicator_in, bus_power_ok_cmp, session_ok_cmp;
  logic bus_power_drain_en, bus_power_pulse_up_en, ext_supply_enable_out;
  logic ext_indicator_pulldown_en, rxcmd_bus_power_ok, rxcmd_session_ok;
  logic [7:0] d;
  logic [4:0] v;
  logic e;
  int n_fail = 0;
  int n_checks = 0;
  otgvb_ctrl u_otgvb_ctrl (.mclk, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .ext_indicator_in, .bus_power_ok_cmp, .session_ok_cmp, .bus_power_drain_en,
    .bus_power_pulse_up_en, .ext_supply_enable_out, .ext_indicator_pulldown_en,
    .rxcmd_bus_power_ok, .rxcmd_session_ok);
  otgvb_link_model u_otgvb_link_model (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // the whole run needs well under 500 cycles
  initial begin
    #20000;
    n_fail++;
    results();
  end
  initial begin
    reset_n = 1'b0;
    ext_indicator_in = 1'b0;
    bus_power_ok_cmp = 1'b0;
    session_ok_cmp = 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1;
    chk("supply", {7'h00, ext_supply_enable_out}, 8'h00);
    chk("pulldown", {7'h00, ext_indicator_pulldown_en}, 8'h01);
    u_otgvb_link_model.rd(OTGVB_SESSION_CTRL_ADDR);
    #1;
    chk("session reset", reg_rdata, OTGVB_SESSION_CTRL_RST);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = 8'h01 << i;
      u_otgvb_link_model.wr(OTGVB_SESSION_CTRL_ADDR, d);
      @(posedge mclk);
      #1;
      chk("drain", {7'h00, bus_power_drain_en}, {7'h00, d[3]});
      chk("pulse up", {7'h00, bus_power_pulse_up_en}, {7'h00, d[4]});
      chk("supply", {7'h00, ext_supply_enable_out}, {7'h00, d[5] | d[6]});
      chk("pulldown", {7'h00, ext_indicator_pulldown_en}, {7'h00, !d[7]});
      u_otgvb_link_model.rd(OTGVB_SESSION_CTRL_ADDR);
      #1;
      chk("session readback", reg_rdata, d);
    end
    $display("test session bits done");
    // every select, bypass and invert setting against every indicator and bus comparator pin combination
    for (int m = 0; m < 32; m++) begin
      v = m[4:0];
      u_otgvb_link_model.wr(OTGVB_SESSION_CTRL_ADDR, {v[4], 7'h00});
      u_otgvb_link_model.wr(OTGVB_LINK_IF_CTRL_ADDR, {1'b0, v[3], v[2], 5'h00});
      ext_indicator_in <= v[1];
      bus_power_ok_cmp <= v[0];
      session_ok_cmp <= v[1] ^ v[0];
      repeat (4) @(posedge mclk);
      #1;
      e = v[4] ? (v[3] ? v[1] ^ v[2] : (v[1] ^ v[2]) & v[0]) : v[0];
      chk("bus ok", {7'h00, rxcmd_bus_power_ok}, {7'h00, e});
      chk("session ok", {7'h00, rxcmd_session_ok}, {7'h00, v[1] ^ v[0]});
    end
    $display("test source select done");
    u_otgvb_link_model.wr(6'h2A, 8'hFF);
    u_otgvb_link_model.rd(6'h2A);
    #1;
    chk("unmapped read", reg_rdata, 8'h00);
    u_otgvb_link_model.rd(OTGVB_SESSION_CTRL_ADDR);
    #1;
    chk("session kept", reg_rdata, 8'h80);
    u_otgvb_link_model.rd(OTGVB_LINK_IF_CTRL_ADDR);
    #1;
    chk("iface kept", reg_rdata, 8'h60);
    $display("test unmapped done");
    results();
  end
endmodule : otg_vbus_control_logic_tb
